// ==== pkg/fmd_pkg.sv ====
// constants for the arithmetic microinstruction decoder
package fmd_pkg;
  // =====================================================
  // field positions in the 40-bit microinstruction word
  localparam int WORD_W = 40;
  localparam int F_MALU_HI = 39;
  localparam int F_MALU_LO = 38;
  localparam int F_MALU_INV_BIT = 37;
  localparam int F_INV_HI = 36;
  localparam int F_INV_LO = 35;
  localparam int F_SUB_INV = 34;
  localparam int F_EXPONENT_ALU_HI = 33;
  localparam int F_EXPONENT_ALU_LO = 32;
  localparam int F_BCLK = 31;
  localparam int F_ACLK_HIGH = 30;
  localparam int F_ACLK_MID = 29;
  localparam int F_ACLK_LOW = 28;
  localparam int F_MODE_HI = 27;
  localparam int F_MODE_LO = 26;
  localparam int F_EXP_CLK = 25;
  localparam int F_HALT = 24;
  localparam int F_MB_HI = 23;
  localparam int F_MB_LO = 21;
  localparam int F_EB_HI = 20;
  localparam int F_EB_LO = 19;
  localparam int F_EB_GATE = 18;
  localparam int F_LOAD_SC = 17;
  localparam int F_LARGER_EN = 16;
  localparam int F_INH_HI = 15;
  localparam int F_INH_LO = 14;
  localparam int F_HW_HI = 10;
  localparam int F_HW_LO = 8;
  // =====================================================
  // field codes
  localparam logic [1:0] INV_ACC_SIGN = 2'h1;
  localparam logic [1:0] INV_OPERAND = 2'h2;
  localparam logic [1:0] INV_B_SIGN = 2'h3;
  localparam logic [2:0] HW_MPY = 3'h1;
  localparam logic [2:0] HW_DIV = 3'h2;
  localparam logic [1:0] MODE_RIGHT = 2'h1;
  localparam logic [1:0] MODE_LEFT = 2'h2;
  localparam logic [1:0] MODE_LOAD = 2'h0;
  localparam logic [2:0] MB_ZERO = 3'h0;
  localparam logic [2:0] MB_MD = 3'h1;
  localparam logic [2:0] MB_SECONDARY_B_REGISTER = 3'h2;
  localparam logic [2:0] MB_MAX_INT = 3'h3;
  localparam logic [2:0] MB_MAX_FLT = 3'h4;
  localparam logic [2:0] MB_ROUND = 3'h5;
  localparam logic [2:0] MB_FIX = 3'h6;
  localparam logic [2:0] MB_FZERO = 3'h7;
  localparam logic [1:0] INH_NORMALIZED = 2'h3;
  // =====================================================
  // exponent constants, 10 bits (bit -2 is the sign)
  localparam int EXP_W = 10;
  localparam int SC_W = 9;
  localparam logic [9:0] EXP_ZERO = 10'h000;
  localparam logic [9:0] EXP_ONE = 10'h001;
  localparam logic [9:0] EXP_15 = 10'h00F;
  localparam logic [9:0] EXP_23 = 10'h017;
  localparam logic [9:0] EXP_127 = 10'h07F;
  localparam logic [9:0] EXP_NEG_127 = 10'h381;
  localparam logic [8:0] CMP_FIX = 9'h016;
  localparam logic [8:0] CMP_DEFAULT = 9'h00F;
  localparam logic [15:0] MAX_NEG_INT = 16'h8000;
  typedef enum logic {FMD_IDLE, FMD_RUN} fmd_state_t;
endpackage

// ==== rtl/fmd_shift_load.sv ====
// shift counter and larger-exponent flag loaded from the exponent alu
module fmd_shift_load #(
  parameter int SC_W = 9
) (
  input wire logic clk_i, // system clock
  input wire logic reset_i, // async reset, active high
  input wire logic load_i, // load strobe
  input wire logic [SC_W:0] exp_alu_out_i, // exponent alu output, msb is sign
  output logic [SC_W-1:0] shift_count_o, // loaded magnitude
  output logic larger_exponent_flag_o // set for positive sign
);
  logic sign;
  logic [SC_W-1:0] mag;

  assign sign = exp_alu_out_i[SC_W];
  // negative values are inverted, giving the one's-complement magnitude
  assign mag = sign ? ~exp_alu_out_i[SC_W-1:0] : exp_alu_out_i[SC_W-1:0];

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      shift_count_o <= '0;
      larger_exponent_flag_o <= 1'b0;
    end
    else if (load_i)
    begin
      shift_count_o <= mag;
      larger_exponent_flag_o <= ~sign;
    end
  end
endmodule

// ==== rtl/fmd_decoder.sv ====
// arithmetic micro-sequencer word register, busy control and field decode
module fmd_decoder #(
  parameter logic [8:0] CMP_DEFAULT = fmd_pkg::CMP_DEFAULT
) (
  input wire logic clk_i, // system clock
  input wire logic reset_i, // async reset, active high
  input wire logic start_i, // master start pulse, word 0 on uword_i
  input wire logic step_i, // microinstruction clock strobe
  input wire logic [39:0] uword_i, // next microinstruction word
  input wire logic acc_sign_i, // accumulator mantissa bit 0
  input wire logic md_sign_i, // multiplicand/divisor register sign
  input wire logic secondary_b_register_sign_i, // secondary b register sign
  input wire logic float_subtract_command_i, // current sequence is float subtract
  input wire logic acc_normalized_i, // accumulator is normalized
  input wire logic acc_short_i, // accumulator one position short
  input wire logic double_precision_i, // double precision mode
  input wire logic [3:0] round_guard_i, // guard bits by {dp, short}
  input wire logic [9:0] exp_alu_out_i, // exponent alu output
  output logic busy_o, // sequencer running
  output logic [2:0] mant_alu_func_o, // mantissa alu function
  output logic [1:0] exp_alu_func_o, // exponent alu function
  output logic b_clk_o, // clock b register at next step
  output logic acc_high_clock_o, // clock accumulator bits 0, 9..15
  output logic acc_middle_clock_o, // clock accumulator bits 16..31
  output logic acc_low_clock_o, // clock accumulator bits 32..51
  output logic exponent_clock_o, // clock accumulator exponent
  output logic [1:0] shift_mode_o, // 1 right, 2 left, 0 load
  output logic b_side_mux_en_o, // b-side mux enabled
  output logic b_side_mux_sel_b_o, // mux selects b register
  output logic mant_b_zero_o, // zeros on mantissa b
  output logic max_negative_integer_source_o, // 8000 on bits 16..31
  output logic max_negative_float_source_o, // max negative mantissa
  output logic round_en_o, // round on mantissa b
  output logic round_bit_o, // selected guard bit
  output logic round_subtract_o, // subtract round bit
  output logic [8:0] cmp_value_o, // magnitude comparator value
  output logic float_zero_source_o, // zero value on mantissa b
  output logic [15:0] max_int_value_o, // constant for bits 16..31
  output logic [9:0] exp_b_value_o, // exponent alu b constant
  output logic exponent_b_gate_o, // md onto exponent b
  output logic [8:0] shift_count_o, // shift counter
  output logic larger_exponent_flag_o // larger-exponent flag
);
  // =====================================================
  // sequencer state and word register
  fmd_pkg::fmd_state_t state_r;
  fmd_pkg::fmd_state_t state_nxt;
  logic [39:0] word_r;
  logic run;
  logic take_word;
  logic halt_now;
  logic load_sc;

  assign run = (state_r == fmd_pkg::FMD_RUN);
  assign take_word = (!run && start_i) || (run && step_i);
  assign halt_now = run && step_i && word_r[fmd_pkg::F_HALT];

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      fmd_pkg::FMD_IDLE:
        if (start_i)
          state_nxt = fmd_pkg::FMD_RUN;
      fmd_pkg::FMD_RUN:
        if (halt_now)
          state_nxt = fmd_pkg::FMD_IDLE;
      default:
        state_nxt = fmd_pkg::FMD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= fmd_pkg::FMD_IDLE;
      word_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (take_word)
        word_r <= uword_i;
    end
  end

  // =====================================================
  // mantissa alu function and conditional inversion
  logic [1:0] inv_code;
  logic [2:0] hw_code;
  logic field_cond;
  logic sub_cond;
  logic inv37;
  logic [2:0] mant_func;

  assign inv_code = word_r[fmd_pkg::F_INV_HI:fmd_pkg::F_INV_LO];
  assign hw_code = word_r[fmd_pkg::F_HW_HI:fmd_pkg::F_HW_LO];
  // acc sign, operand sign, b sign
  assign field_cond = (inv_code == fmd_pkg::INV_ACC_SIGN) ? acc_sign_i :
    (inv_code == fmd_pkg::INV_OPERAND) ?
      ((hw_code == fmd_pkg::HW_MPY) && (acc_sign_i ^ md_sign_i)) ||
      ((hw_code == fmd_pkg::HW_DIV) && md_sign_i) :
    (inv_code == fmd_pkg::INV_B_SIGN) ? secondary_b_register_sign_i : 1'b0;
  assign sub_cond = word_r[fmd_pkg::F_SUB_INV] && float_subtract_command_i;
  // either source flips bit 37 once; both together do not cancel
  assign inv37 = field_cond || sub_cond;
  assign mant_func = {word_r[fmd_pkg::F_MALU_HI:fmd_pkg::F_MALU_LO], word_r[fmd_pkg::F_MALU_INV_BIT] ^ inv37};

  // =====================================================
  // register clocks with flag swap and normalize inhibit
  logic swap;
  logic norm_inh;
  logic b_clk_nxt;
  logic [2:0] acc_clk_nxt;
  logic exp_clk_nxt;

  // larger flag moves clocks to b register
  assign swap = word_r[fmd_pkg::F_LARGER_EN] && larger_exponent_flag_o;
  assign norm_inh = (word_r[fmd_pkg::F_INH_HI:fmd_pkg::F_INH_LO] == fmd_pkg::INH_NORMALIZED) && acc_normalized_i;
  assign b_clk_nxt = word_r[fmd_pkg::F_BCLK] || swap;
  assign acc_clk_nxt = (swap || norm_inh) ? 3'h0 : word_r[fmd_pkg::F_ACLK_HIGH:fmd_pkg::F_ACLK_LOW];
  assign exp_clk_nxt = word_r[fmd_pkg::F_EXP_CLK] && !norm_inh;

  // =====================================================
  // b-side sources
  logic [2:0] mb;
  logic [1:0] eb;
  logic [1:0] mode;
  logic [9:0] exp_b_nxt;
  logic round_nxt;

  assign mb = word_r[fmd_pkg::F_MB_HI:fmd_pkg::F_MB_LO];
  assign eb = word_r[fmd_pkg::F_EB_HI:fmd_pkg::F_EB_LO];
  assign mode = (word_r[fmd_pkg::F_MODE_HI:fmd_pkg::F_MODE_LO] == fmd_pkg::MODE_RIGHT) ? fmd_pkg::MODE_RIGHT :
    (word_r[fmd_pkg::F_MODE_HI:fmd_pkg::F_MODE_LO] == fmd_pkg::MODE_LEFT) ? fmd_pkg::MODE_LEFT : fmd_pkg::MODE_LOAD;
  // max-float and float-zero b-side codes override the exponent field, otherwise
  assign exp_b_nxt = (mb == fmd_pkg::MB_MAX_FLT) ? fmd_pkg::EXP_127 :
    (mb == fmd_pkg::MB_FZERO) ? fmd_pkg::EXP_NEG_127 :
    (eb == 2'h1) ? fmd_pkg::EXP_ONE :
    (eb == 2'h2) ? fmd_pkg::EXP_15 :
    (eb == 2'h3) ? fmd_pkg::EXP_23 : fmd_pkg::EXP_ZERO;
  // guard bit picked by precision and normalization
  assign round_nxt = round_guard_i[{double_precision_i, acc_short_i}];

  // =====================================================
  // output registers
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      busy_o <= 1'b0;
      mant_alu_func_o <= 3'h0;
      exp_alu_func_o <= 2'h0;
      shift_mode_o <= fmd_pkg::MODE_LOAD;
    end
    else
    begin
      busy_o <= (state_nxt == fmd_pkg::FMD_RUN);
      mant_alu_func_o <= mant_func;
      exp_alu_func_o <= word_r[fmd_pkg::F_EXPONENT_ALU_HI:fmd_pkg::F_EXPONENT_ALU_LO];
      shift_mode_o <= mode;
    end
  end

  // clocks only while running so an idle sequencer disturbs nothing
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      b_clk_o <= 1'b0;
      {acc_high_clock_o, acc_middle_clock_o, acc_low_clock_o} <= 3'h0;
      exponent_clock_o <= 1'b0;
    end
    else
    begin
      b_clk_o <= run && b_clk_nxt;
      {acc_high_clock_o, acc_middle_clock_o, acc_low_clock_o} <= run ? acc_clk_nxt : 3'h0;
      exponent_clock_o <= run && exp_clk_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      b_side_mux_en_o <= 1'b0;
      b_side_mux_sel_b_o <= 1'b0;
      mant_b_zero_o <= 1'b1;
      max_negative_integer_source_o <= 1'b0;
      max_negative_float_source_o <= 1'b0;
      round_en_o <= 1'b0;
      round_bit_o <= 1'b0;
      round_subtract_o <= 1'b0;
      cmp_value_o <= 9'h000;
      float_zero_source_o <= 1'b0;
      max_int_value_o <= 16'h0000;
      exp_b_value_o <= 10'h000;
      exponent_b_gate_o <= 1'b0;
    end
    else
    begin
      mant_b_zero_o <= (mb == fmd_pkg::MB_ZERO) || (mb == fmd_pkg::MB_FZERO);
      b_side_mux_en_o <= (mb == fmd_pkg::MB_MD) || (mb == fmd_pkg::MB_SECONDARY_B_REGISTER);
      b_side_mux_sel_b_o <= (mb == fmd_pkg::MB_SECONDARY_B_REGISTER);
      max_negative_integer_source_o <= (mb == fmd_pkg::MB_MAX_INT);
      max_int_value_o <= fmd_pkg::MAX_NEG_INT;
      max_negative_float_source_o <= (mb == fmd_pkg::MB_MAX_FLT);
      round_en_o <= (mb == fmd_pkg::MB_ROUND);
      round_bit_o <= round_nxt;
      round_subtract_o <= acc_sign_i;
      cmp_value_o <= (mb == fmd_pkg::MB_FIX) ? fmd_pkg::CMP_FIX : CMP_DEFAULT;
      float_zero_source_o <= (mb == fmd_pkg::MB_FZERO);
      exp_b_value_o <= exp_b_nxt;
      exponent_b_gate_o <= word_r[fmd_pkg::F_EB_GATE];
    end
  end

  // =====================================================
  // shift counter and larger-exponent flag
  // load on the step that leaves this word
  assign load_sc = run && step_i && word_r[fmd_pkg::F_LOAD_SC];

  fmd_shift_load #(
    .SC_W(fmd_pkg::SC_W)
  ) u_shift (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(load_sc),
    .exp_alu_out_i(exp_alu_out_i),
    .shift_count_o(shift_count_o),
    .larger_exponent_flag_o(larger_exponent_flag_o)
  );

  // =====================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  alu_code_a: assert property (1'b1 |=> mant_alu_func_o[2:1] == $past(word_r[39:38]))
    else $error("mantissa alu code high bits wrong");
  acc_inv_a: assert property ((inv_code == 2'h1 && !word_r[34]) |=>
    mant_alu_func_o[0] == ($past(word_r[37]) ^ $past(acc_sign_i)))
    else $error("accumulator sign inversion wrong");
  sub_inv_a: assert property ((inv_code == 2'h0 && word_r[34]) |=>
    mant_alu_func_o[0] == ($past(word_r[37]) ^ $past(float_subtract_command_i)))
    else $error("float subtract inversion wrong");
  exp_func_a: assert property (1'b1 |=> exp_alu_func_o == $past(word_r[33:32]))
    else $error("exponent alu function wrong");
  halt_busy_a: assert property (halt_now |=> !busy_o ##1 (!busy_o || $past(start_i)))
    else $error("busy not dropped after halt");
  fix_cmp_a: assert property ((mb == 3'h6) |=> cmp_value_o == 9'h016)
    else $error("comparison value not 22");
  zero_exp_a: assert property ((mb == 3'h7) |=> exp_b_value_o == 10'h381 && mant_b_zero_o)
    else $error("float zero constants wrong");
  flag_swap_a: assert property ((run && swap) |=> b_clk_o && !acc_high_clock_o && !acc_low_clock_o)
    else $error("larger flag clock swap wrong");
  norm_inh_a: assert property ((run && norm_inh) |=> !exponent_clock_o && !acc_middle_clock_o)
    else $error("normalized inhibit failed");
  sc_load_a: assert property ((load_sc && exp_alu_out_i[9]) |=>
    !larger_exponent_flag_o && shift_count_o == ~$past(exp_alu_out_i[8:0]))
    else $error("shift count load wrong");

  halt_c: cover property (start_i ##[1:20] halt_now);
  swap_c: cover property (run && swap);
  round_c: cover property (run && mb == 3'h5 && acc_sign_i);
endmodule

// ==== test/fmd_master_model.sv ====
// master command sequencer model driving start and step strobes of the decoder
module fmd_master_model (
  input wire logic clk_i, // system clock
  input wire logic reset_i, // async reset, active high
  input wire logic busy_i, // arithmetic sequencer busy
  output logic start_o, // start pulse
  output logic step_o, // microinstruction strobe
  output logic [39:0] uword_o // word presented with a strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    start_o = 1'b0;
    step_o = 1'b0;
    uword_o = 40'h0;
  end
  // =====================================================
  // strobe and word held until 2 ns past the sampling edge
  task automatic send(input logic first, input logic [39:0] w);
    start_o = first;
    step_o = ~first;
    uword_o = w;
    @(posedge clk_i);
    #2;
    start_o = 1'b0;
    step_o = 1'b0;
    // released word shows junk, never the last value
    uword_o = ~w;
  endtask
  task automatic wait_idle(output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 50; n++)
    begin
      if (busy_i === 1'b0)
      begin
        ok = 1'b1;
        break;
      end
      @(posedge clk_i);
      #2;
    end
  endtask
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the arithmetic microinstruction decoder
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_i, start_i, step_i, acc_sign_i, md_sign_i, secondary_b_register_sign_i, float_subtract_command_i;
  logic acc_normalized_i, acc_short_i, double_precision_i, busy_o, b_clk_o, acc_high_clock_o;
  logic acc_middle_clock_o, acc_low_clock_o, exponent_clock_o, b_side_mux_en_o, b_side_mux_sel_b_o;
  logic mant_b_zero_o, max_negative_integer_source_o, max_negative_float_source_o, round_en_o;
  logic round_bit_o, round_subtract_o, float_zero_source_o, exponent_b_gate_o, larger_exponent_flag_o;
  logic [39:0] uword_i;
  logic [3:0] round_guard_i;
  logic [9:0] exp_alu_out_i, exp_b_value_o;
  logic [2:0] mant_alu_func_o;
  logic [1:0] exp_alu_func_o, shift_mode_o;
  logic [8:0] cmp_value_o, shift_count_o;
  logic [15:0] max_int_value_o;
  int err_count = 0;
  int checked = 0;
  fmd_decoder i_dut (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .step_i(step_i), .uword_i(uword_i),
    .acc_sign_i(acc_sign_i), .md_sign_i(md_sign_i), .secondary_b_register_sign_i(secondary_b_register_sign_i),
    .float_subtract_command_i(float_subtract_command_i), .acc_normalized_i(acc_normalized_i),
    .acc_short_i(acc_short_i), .double_precision_i(double_precision_i), .round_guard_i(round_guard_i),
    .exp_alu_out_i(exp_alu_out_i), .busy_o(busy_o), .mant_alu_func_o(mant_alu_func_o),
    .exp_alu_func_o(exp_alu_func_o), .b_clk_o(b_clk_o), .acc_high_clock_o(acc_high_clock_o),
    .acc_middle_clock_o(acc_middle_clock_o), .acc_low_clock_o(acc_low_clock_o),
    .exponent_clock_o(exponent_clock_o), .shift_mode_o(shift_mode_o), .b_side_mux_en_o(b_side_mux_en_o),
    .b_side_mux_sel_b_o(b_side_mux_sel_b_o), .mant_b_zero_o(mant_b_zero_o),
    .max_negative_integer_source_o(max_negative_integer_source_o),
    .max_negative_float_source_o(max_negative_float_source_o), .round_en_o(round_en_o),
    .round_bit_o(round_bit_o), .round_subtract_o(round_subtract_o), .cmp_value_o(cmp_value_o),
    .float_zero_source_o(float_zero_source_o), .max_int_value_o(max_int_value_o),
    .exp_b_value_o(exp_b_value_o), .exponent_b_gate_o(exponent_b_gate_o), .shift_count_o(shift_count_o),
    .larger_exponent_flag_o(larger_exponent_flag_o));
  fmd_master_model i_master (.clk_i(clk_i), .reset_i(reset_i), .busy_i(busy_o), .start_o(start_i),
    .step_o(step_i), .uword_o(uword_i));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // =====================================================
  // tasks
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // word taken at the next edge, decode visible one edge later
  task automatic run(input logic [39:0] w);
    i_master.send(1'b0, w);
    @(posedge clk_i);
    #2;
  endtask
  task automatic inv(input logic [1:0] f, input logic b34, input logic [2:0] hw, input logic [3:0] s,
    input logic [2:0] ex);
    {acc_sign_i, md_sign_i, secondary_b_register_sign_i, float_subtract_command_i} = s;
    run({3'h4, f, b34, 23'h0, hw, 8'h0});
    chk("mant_alu_func", 16'(ex), 16'(mant_alu_func_o));
  endtask
  // =====================================================
  // main sequence
  initial
  begin
    bit ok;
    int i;
    int clkbit[5];
    logic [9:0] eb[4];
    logic [6:0] e;
    logic [39:0] clks;
    clkbit = '{31, 30, 29, 28, 25};
    eb = '{10'h000, 10'h001, 10'h00F, 10'h017};
    clks = (40'hF << 28) | (40'h1 << 25);
    reset_i = 1'b1;
    {acc_sign_i, md_sign_i, secondary_b_register_sign_i, float_subtract_command_i} = 4'h0;
    {acc_normalized_i, acc_short_i, double_precision_i} = 3'h0;
    round_guard_i = 4'h0;
    exp_alu_out_i = 10'h000;
    repeat (8) @(posedge clk_i);
    #2;
    reset_i = 1'b0;
    chk("mant_b_zero", 16'h1, 16'(mant_b_zero_o));
    i_master.send(1'b1, 40'h0);
    chk("busy", 16'h1, 16'(busy_o));
    @(posedge clk_i);
    #2;
    for (i = 0; i < 8; i++)
    begin
      run({i[2:0], 37'h0});
      chk("mant_alu_func", 16'(i), 16'(mant_alu_func_o));
    end
    for (i = 0; i < 4; i++)
    begin
      run({6'h0, i[1:0], 32'h0});
      chk("exp_alu_func", 16'(i), 16'(exp_alu_func_o));
      run({12'h0, i[1:0], 26'h0});
      chk("shift_mode", 16'((i == 3) ? 0 : i), 16'(shift_mode_o));
      run({19'h0, i[1:0], 19'h0});
      chk("exp_b_value", 16'(eb[i]), 16'(exp_b_value_o));
      chk("exponent_b_gate", 16'h0, 16'(exponent_b_gate_o));
    end
    run(40'h1 << 18);
    chk("exponent_b_gate", 16'h1, 16'(exponent_b_gate_o));
    for (i = 0; i < 5; i++)
    begin
      run(40'h1 << clkbit[i]);
      chk("clocks", 16'(5'h10 >> i), 16'({b_clk_o, acc_high_clock_o, acc_middle_clock_o, acc_low_clock_o,
        exponent_clock_o}));
    end
    inv(2'h0, 1'b0, 3'h0, 4'hF, 3'h4);
    inv(2'h1, 1'b0, 3'h0, 4'h8, 3'h5);
    inv(2'h1, 1'b0, 3'h0, 4'h7, 3'h4);
    inv(2'h2, 1'b0, 3'h1, 4'h8, 3'h5);
    inv(2'h2, 1'b0, 3'h1, 4'hC, 3'h4);
    inv(2'h2, 1'b0, 3'h2, 4'h4, 3'h5);
    inv(2'h2, 1'b0, 3'h2, 4'h8, 3'h4);
    inv(2'h3, 1'b0, 3'h0, 4'h2, 3'h5);
    inv(2'h3, 1'b0, 3'h0, 4'hD, 3'h4);
    inv(2'h0, 1'b1, 3'h0, 4'h1, 3'h5);
    inv(2'h0, 1'b1, 3'h0, 4'hE, 3'h4);
    {acc_sign_i, double_precision_i, round_guard_i} = 6'h34;
    for (i = 0; i < 8; i++)
    begin
      run({16'h0, i[2:0], 2'h2, 19'h0});
      e = {i == 1 || i == 2, i == 2, i == 0 || i == 7, i == 3, i == 4, i == 5, i == 7};
      chk("b_side_flags", 16'(e), 16'({b_side_mux_en_o, b_side_mux_sel_b_o, mant_b_zero_o,
        max_negative_integer_source_o, max_negative_float_source_o, round_en_o, float_zero_source_o}));
      chk("cmp_value", (i == 6) ? 16'h0016 : 16'h000F, 16'(cmp_value_o));
      chk("exp_b_value", (i == 4) ? 16'h007F : (i == 7) ? 16'h0381 : 16'h000F, 16'(exp_b_value_o));
      if (i == 5)
        chk("round", 16'h3, 16'({round_bit_o, round_subtract_o}));
    end
    acc_sign_i = 1'b0;
    @(posedge clk_i);
    #2;
    chk("round", 16'h2, 16'({round_bit_o, round_subtract_o}));
    chk("max_int_value", 16'h8000, max_int_value_o);
    exp_alu_out_i = 10'h005;
    run(40'h1 << 17);
    run(clks | (40'h1 << 16));
    chk("shift_count", 16'h5, 16'(shift_count_o));
    chk("flag", 16'h1, 16'(larger_exponent_flag_o));
    chk("clocks", 16'h11, 16'({b_clk_o, acc_high_clock_o, acc_middle_clock_o, acc_low_clock_o,
      exponent_clock_o}));
    exp_alu_out_i = 10'h3FA;
    run(40'h1 << 17);
    run(clks | (40'h1 << 16));
    chk("shift_count", 16'h5, 16'(shift_count_o));
    chk("clocks", 16'h0F, 16'({larger_exponent_flag_o, acc_high_clock_o, acc_middle_clock_o,
      acc_low_clock_o, exponent_clock_o}));
    for (i = 1; i >= 0; i--)
    begin
      acc_normalized_i = i[0];
      run(clks | (40'h3 << 14));
      chk("clocks", i[0] ? 16'h0 : 16'hF, 16'({acc_high_clock_o, acc_middle_clock_o, acc_low_clock_o,
        exponent_clock_o}));
    end
    run(40'h1 << 24);
    chk("busy", 16'h1, 16'(busy_o));
    i_master.send(1'b0, 40'h1 << 31);
    chk("busy", 16'h0, 16'(busy_o));
    i_master.wait_idle(ok);
    chk("idle", 16'h1, 16'(ok));
    if (ok)
    begin
      // a step while idle must be ignored
      run(40'h1 << 30);
      chk("clocks", 16'h0, 16'({b_clk_o, acc_high_clock_o, busy_o}));
    end
    results();
  end
endmodule
